/* File: logic/cs_pkg.sv */
// constants, states and carriers for the clock safeguard and reset sequencer
package cs_pkg;

    // ==========================================
    // clock and timing
    localparam int CORE_CLK_HZ = 20_000_000;
    localparam int SG_MAX_FREQ_HI_HZ = 4_000_000;
    localparam int SG_MAX_FREQ_LO_HZ = 2_000_000;
    localparam int BACKUP_CLOCK_FREQ_HZ = 1_000_000;
    localparam int MAIN_MISS_NS = 800;
    localparam int WDG_PIN_PULSE_NS = 100;
    localparam int SG_GAP_HI_CYC = (CORE_CLK_HZ + SG_MAX_FREQ_HI_HZ - 1) / SG_MAX_FREQ_HI_HZ;
    localparam int SG_GAP_LO_CYC = (CORE_CLK_HZ + SG_MAX_FREQ_LO_HZ - 1) / SG_MAX_FREQ_LO_HZ;
    localparam int BACKUP_PERIOD_CYC = CORE_CLK_HZ / BACKUP_CLOCK_FREQ_HZ;
    localparam int MAIN_MISS_CYC = (MAIN_MISS_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WDG_PIN_CYC = (WDG_PIN_PULSE_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 12;

    // ==========================================
    // reset sequence
    localparam logic [CNT_W-1:0] RESET_DELAY_TICKS = 12'h800;
    localparam logic [1:0] VECTOR_FETCH_TICKS = 2'h2;
    localparam logic [11:0] RESET_VECTOR = 12'hFFE;
    localparam logic [2:0] PIN_MASK_DEPTH = 3'h3;

    // ==========================================
    // register map
    localparam logic [7:0] ADDR_ANALOG_CONVERTER_CONTROL = 8'hD1;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'hD2;
    localparam logic [7:0] ANALOG_CONVERTER_CONTROL_RESET = 8'h40;
    localparam int MAIN_OSC_OFF_BIT = 2;
    localparam int ST_MAIN_RUN_BIT = 0;
    localparam int ST_BACKUP_BIT = 1;
    localparam int ST_SUPPLY_OK_BIT = 2;
    localparam int ST_CORE_RUN_BIT = 3;
    localparam int ST_SEL_BACKUP_BIT = 4;

    // ==========================================
    // types
    typedef enum logic [3:0] {
        SEQ_HOLD = 4'b0001,
        SEQ_DELAY = 4'b0010,
        SEQ_FETCH = 4'b0100,
        SEQ_RUN = 4'b1000
    } cs_seq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cs_bus_req_t;

    typedef struct packed {
        logic core_rst_n;
        logic io_safe_input;
        logic stack_clear;
        logic nmi_ctx_set;
        logic vector_fetch;
        logic [11:0] pc_load;
    } cs_core_ctl_t;

endpackage : cs_pkg

/* File: logic/cs_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
module cs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // ==========================================
    // stages
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : cs_sync

/* File: logic/cs_clock_reset.sv */
// clock safeguard, backup oscillator control and reset sequencer
//
// Contract
// - safeguard active: drop input cycles so internal clock stays below supply-dependent max
// - backup oscillator runs only when the safeguard option is set
// - backup starts one own period after first missing main edge, any cause
// - backup stops and clock returns to main once main is running
// - at power-on delay counter runs on backup until main starts, then main
// - control bit 2 set stops main oscillator, clear keeps it enabled
// - main oscillator off bit ignored unless the safeguard option is set
// - converter control register at D1h, read/write, resets to 40h
// - supply monitor holds reset below threshold, rising/falling hysteresis
// - reset pin driven low during a supply monitor reset
// - reset sources: pin low, watchdog request, supply monitor request
// - after release wait 2048 internal clock cycles before vector fetch
// - vector fetch lasts exactly two internal clock cycles
// - reset clears the return stack and loads program counter with FFEh
// - reset sets interrupt context; software leaves it with return_from_interrupt
// - pin honoured in run, wait and stop; reset held while pin low
// - short pin pulses accepted because the delay is appended
// - pin low in run/wait: halt, inputs with pull-up, restart main oscillator
// - pin low in stop: start oscillator, inputs with pull-up
// - watchdog request raised when watchdog not refreshed before end of count
// - watchdog reset acts like pin reset, pin pulsed low briefly
// - after reset the core uses the interrupt-context flag pair first
`timescale 1ns/1ps
module cs_clock_reset (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // option bits
    input wire logic safeguard_option_enable,
    input wire logic supply_monitor_option,
    // supply comparators
    input wire logic supply_high,
    input wire logic above_rising_threshold,
    input wire logic above_falling_threshold,
    // main oscillator edges, one pulse per edge
    input wire logic main_osc_edge,
    // core state and watchdog
    input wire logic cpu_stop_mode,
    input wire logic watchdog_expired,
    // reset pin, open drain
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // register port
    input wire cs_pkg::cs_bus_req_t bus_req,
    output logic [7:0] rdata,
    // clock outputs
    output logic int_tick,
    output logic main_osc_stop,
    output logic backup_run,
    // core control
    output cs_pkg::cs_core_ctl_t core_ctl
);
    import cs_pkg::*;

    logic pin_sync;
    logic [7:0] analog_converter_control;
    logic supply_ok;
    logic [CNT_W-1:0] miss_cnt;
    logic main_missing;
    logic [CNT_W-1:0] backup_wait;
    logic [CNT_W-1:0] backup_div;
    logic backup_tick;
    logic sel_backup;
    logic [CNT_W-1:0] gap_cnt;
    logic [CNT_W-1:0] gap_limit;
    logic cand_tick;
    logic next_int_tick;
    logic [CNT_W-1:0] wdg_cnt;
    logic drive_low;
    logic [PIN_MASK_DEPTH-1:0] drive_hist;
    logic reset_event;
    cs_seq_t seq;
    logic [CNT_W-1:0] seq_cnt;
    logic off_effective;

    // ==========================================
    // pin synchroniser
    cs_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .d(rst_pin_in),
        .q(pin_sync)
    );

    // ==========================================
    // converter control register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            analog_converter_control <= ANALOG_CONVERTER_CONTROL_RESET;
        end else if (seq == SEQ_HOLD) begin
            // reset clears the off bit, restarting the main oscillator
            analog_converter_control <= ANALOG_CONVERTER_CONTROL_RESET;
        end else if (bus_req.wr && bus_req.addr == ADDR_ANALOG_CONVERTER_CONTROL) begin
            analog_converter_control <= bus_req.wdata;
        end
    end

    // off bit only acts with the safeguard option
    assign off_effective = analog_converter_control[MAIN_OSC_OFF_BIT]
                           && safeguard_option_enable;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_ANALOG_CONVERTER_CONTROL: begin
                    rdata <= analog_converter_control;
                end
                ADDR_SEQ_STATUS: begin
                    rdata <= 8'h00;
                    rdata[ST_MAIN_RUN_BIT] <= !main_missing;
                    rdata[ST_BACKUP_BIT] <= backup_run;
                    rdata[ST_SUPPLY_OK_BIT] <= supply_ok;
                    rdata[ST_CORE_RUN_BIT] <= (seq == SEQ_RUN);
                    rdata[ST_SEL_BACKUP_BIT] <= sel_backup;
                end
                default: begin
                    rdata <= 8'h00;
                end
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ==========================================
    // main oscillator stop control
    // stop mode stops it too, but any reset hold starts it again
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            main_osc_stop <= 1'b0;
        end else if (seq == SEQ_HOLD) begin
            main_osc_stop <= 1'b0;
        end else begin
            main_osc_stop <= off_effective || cpu_stop_mode;
        end
    end

    // ==========================================
    // missing edge detection
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            miss_cnt <= CNT_W'(MAIN_MISS_CYC);
        end else if (main_osc_edge && !main_osc_stop) begin
            miss_cnt <= '0;
        end else if (miss_cnt != CNT_W'(MAIN_MISS_CYC)) begin
            miss_cnt <= miss_cnt + 1'b1;
        end
    end

    assign main_missing = (miss_cnt == CNT_W'(MAIN_MISS_CYC)) || main_osc_stop;

    // ==========================================
    // backup oscillator start and stop
    // the wait counter models one backup period before it takes over
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            backup_wait <= '0;
            backup_run <= 1'b0;
        end else if (!safeguard_option_enable) begin
            backup_wait <= '0;
            backup_run <= 1'b0;
        end else if (!main_missing) begin
            backup_wait <= '0;
            backup_run <= 1'b0;
        end else if (backup_wait == CNT_W'(BACKUP_PERIOD_CYC)) begin
            backup_run <= 1'b1;
        end else begin
            backup_wait <= backup_wait + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            backup_div <= '0;
            backup_tick <= 1'b0;
        end else if (!backup_run) begin
            backup_div <= '0;
            backup_tick <= 1'b0;
        end else if (backup_div == CNT_W'(BACKUP_PERIOD_CYC - 1)) begin
            backup_div <= '0;
            backup_tick <= 1'b1;
        end else begin
            backup_div <= backup_div + 1'b1;
            backup_tick <= 1'b0;
        end
    end

    // ==========================================
    // source select, changed only between ticks
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sel_backup <= 1'b0;
        end else if (!main_osc_edge && !backup_tick) begin
            sel_backup <= backup_run;
        end
    end

    // ==========================================
    // safeguard filter
    // low supply lowers the ceiling, so the gap grows
    assign gap_limit = supply_high ? CNT_W'(SG_GAP_HI_CYC) : CNT_W'(SG_GAP_LO_CYC);
    assign cand_tick = sel_backup ? backup_tick : (main_osc_edge && !main_osc_stop);

    always_comb begin
        next_int_tick = cand_tick;
        if (safeguard_option_enable && gap_cnt < gap_limit) begin
            next_int_tick = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            gap_cnt <= CNT_W'(SG_GAP_LO_CYC);
            int_tick <= 1'b0;
        end else begin
            int_tick <= next_int_tick;
            if (next_int_tick) begin
                gap_cnt <= 12'h001;
            end else if (gap_cnt != 12'hFFF) begin
                gap_cnt <= gap_cnt + 1'b1;
            end
        end
    end

    // ==========================================
    // supply monitor with hysteresis
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            supply_ok <= 1'b0;
        end else if (!supply_ok && above_rising_threshold) begin
            supply_ok <= 1'b1;
        end else if (supply_ok && !above_falling_threshold) begin
            supply_ok <= 1'b0;
        end
    end

    // ==========================================
    // reset pin drive
    // watchdog only flags the event: too short for the board
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wdg_cnt <= '0;
        end else if (watchdog_expired) begin
            wdg_cnt <= CNT_W'(WDG_PIN_CYC);
        end else if (wdg_cnt != '0) begin
            wdg_cnt <= wdg_cnt - 1'b1;
        end
    end

    assign drive_low = (supply_monitor_option && !supply_ok) || watchdog_expired
                       || (wdg_cnt > 12'h001);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rst_pin_oe <= 1'b0;
            rst_pin_out <= 1'b0;
            drive_hist <= '0;
        end else begin
            rst_pin_oe <= drive_low;
            rst_pin_out <= 1'b0;
            drive_hist <= {drive_hist[PIN_MASK_DEPTH-2:0], rst_pin_oe};
        end
    end

    // ==========================================
    // reset event merge
    // own drive echoes back through the synchroniser; masked so a
    // watchdog flag does not stretch into a pin reset
    assign reset_event = (!pin_sync && drive_hist == '0 && !rst_pin_oe)
                         || watchdog_expired
                         || (supply_monitor_option && !supply_ok);

    // ==========================================
    // sequence state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            seq <= SEQ_HOLD;
            seq_cnt <= '0;
        end else if (reset_event) begin
            seq <= SEQ_HOLD;
            seq_cnt <= '0;
        end else begin
            case (seq)
                SEQ_HOLD: begin
                    seq <= SEQ_DELAY;
                    seq_cnt <= '0;
                end
                SEQ_DELAY: begin
                    if (int_tick) begin
                        if (seq_cnt == RESET_DELAY_TICKS - 1'b1) begin
                            seq <= SEQ_FETCH;
                            seq_cnt <= '0;
                        end else begin
                            seq_cnt <= seq_cnt + 1'b1;
                        end
                    end
                end
                SEQ_FETCH: begin
                    if (int_tick) begin
                        if (seq_cnt == CNT_W'(VECTOR_FETCH_TICKS - 1'b1)) begin
                            seq <= SEQ_RUN;
                            seq_cnt <= '0;
                        end else begin
                            seq_cnt <= seq_cnt + 1'b1;
                        end
                    end
                end
                SEQ_RUN: begin
                    seq_cnt <= '0;
                end
                default: begin
                    seq <= SEQ_HOLD;
                    seq_cnt <= '0;
                end
            endcase
        end
    end

    // ==========================================
    // core control outputs
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            core_ctl.core_rst_n <= 1'b0;
            core_ctl.io_safe_input <= 1'b1;
            core_ctl.stack_clear <= 1'b1;
            core_ctl.nmi_ctx_set <= 1'b1;
            core_ctl.vector_fetch <= 1'b0;
            core_ctl.pc_load <= RESET_VECTOR;
        end else begin
            // core held until fetch ends; pins float high meanwhile
            core_ctl.core_rst_n <= (seq == SEQ_RUN);
            core_ctl.io_safe_input <= (seq != SEQ_RUN);
            core_ctl.stack_clear <= (seq == SEQ_HOLD) || (seq == SEQ_DELAY);
            core_ctl.nmi_ctx_set <= (seq != SEQ_RUN);
            core_ctl.vector_fetch <= (seq == SEQ_FETCH);
            core_ctl.pc_load <= RESET_VECTOR;
        end
    end

endmodule : cs_clock_reset

/* File: testbench/cs_board_model.sv */
// board reset circuitry sharing the open-drain reset pin
`timescale 1ns/1ps
module cs_board_model (
    // device side of the pin
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    // board switch, high = pin pulled low
    input wire logic press,
    // resolved level
    output logic rst_pin_level
);
    // ==========================================
    // wired-and with the pull-up
    // a released pin returns to the pull-up level, never a stale value
    assign rst_pin_level = !(press || (rst_pin_oe && !rst_pin_out));
endmodule : cs_board_model

/* File: testbench/cs_clock_reset_asserts.sv */
// port checker for the clock safeguard and reset sequencer
`timescale 1ns/1ps
module cs_clock_reset_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // inputs
    input wire logic safeguard_option_enable,
    input wire logic supply_monitor_option,
    input wire logic supply_high,
    input wire logic above_falling_threshold,
    input wire logic main_osc_edge,
    input wire logic watchdog_expired,
    input wire logic rst_pin_in,
    input wire cs_pkg::cs_bus_req_t bus_req,
    // outputs
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    input wire logic [7:0] rdata,
    input wire logic int_tick,
    input wire logic backup_run,
    input wire cs_pkg::cs_core_ctl_t core_ctl
);
    import cs_pkg::*;
    // ==========================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    chk_vector_addr: assert property (core_ctl.pc_load == RESET_VECTOR)
        else $error("wrong reset vector");
    chk_wdg_core: assert property (watchdog_expired |-> ##2 core_ctl.io_safe_input && !core_ctl.core_rst_n)
        else $error("watchdog did not reset core");
    chk_fetch_run: assert property ($fell(core_ctl.vector_fetch) |-> ##[0:2] core_ctl.core_rst_n)
        else $error("core not released after fetch");
    chk_pin_holds: assert property (!rst_pin_in [*5] |-> !core_ctl.core_rst_n)
        else $error("core ran with pin low");
    chk_backup_option: assert property (!safeguard_option_enable [*2] |-> !backup_run)
        else $error("backup ran without option");
    chk_backup_drop: assert property (main_osc_edge && backup_run |-> ##[1:2] !backup_run)
        else $error("backup kept after main edge");
    chk_wdg_pin: assert property (watchdog_expired |=> rst_pin_oe && !rst_pin_out)
        else $error("no pin pulse on watchdog");
    chk_supply_pin: assert property (supply_monitor_option && !above_falling_threshold
        |-> ##[1:4] rst_pin_oe)
        else $error("pin not driven in supply reset");
    chk_gap_high: assert property (safeguard_option_enable && supply_high && int_tick
        |=> !int_tick [*4])
        else $error("tick too close, high band");
    chk_gap_low: assert property (safeguard_option_enable && !supply_high && int_tick
        |=> (!int_tick || supply_high) [*8])
        else $error("tick too close, low band");
endmodule : cs_clock_reset_asserts

/* File: testbench/cs_clock_reset_bench.sv */
// self-checking bench for the clock safeguard and reset sequencer
`timescale 1ns/1ps
module cs_clock_reset_bench;
    import cs_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } cs_row_t;
    // status after run: main running, supply ok, core running
    cs_row_t rows [5] = '{'{8'hD1, 8'hBB, 8'hBB}, '{8'hD1, 8'h00, 8'h00},
        '{8'hD1, 8'h40, 8'h40}, '{8'h33, 8'h5A, 8'h00}, '{8'hD2, 8'hFF, 8'h0D}};
    logic core_clk, rstn, safeguard_option_enable, supply_monitor_option, supply_high;
    logic above_rising_threshold, above_falling_threshold, main_osc_edge, watchdog_expired;
    logic press, rst_pin_level, rst_pin_out, rst_pin_oe, int_tick, main_osc_stop, backup_run;
    logic cpu_stop_mode;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [2:0] ph;
    cs_bus_req_t bus_req;
    cs_core_ctl_t core_ctl;
    int n_mismatch, n_checks, i, n;

    cs_clock_reset cs_clock_reset_inst (.core_clk(core_clk), .rstn(rstn),
        .safeguard_option_enable(safeguard_option_enable),
        .supply_monitor_option(supply_monitor_option), .supply_high(supply_high),
        .above_rising_threshold(above_rising_threshold),
        .above_falling_threshold(above_falling_threshold), .main_osc_edge(main_osc_edge),
        .cpu_stop_mode(cpu_stop_mode), .watchdog_expired(watchdog_expired),
        .rst_pin_in(rst_pin_level), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .bus_req(bus_req), .rdata(rdata), .int_tick(int_tick),
        .main_osc_stop(main_osc_stop), .backup_run(backup_run), .core_ctl(core_ctl));
    cs_board_model cs_board_model_inst (.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .press(press), .rst_pin_level(rst_pin_level));

    // ==========================================
    // clock and main oscillator, one edge every 8 cycles
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        ph <= ph + 3'h1;
        main_osc_edge <= (ph == 3'h7) && !main_osc_stop;
    end

    // ==========================================
    // tasks
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            n_mismatch++;
        end
    endtask : cmp_bit
    task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            n_mismatch++;
        end
    endtask : cmp_val
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(posedge core_clk);
        d = rdata;
    endtask : reg_rd
    // release lands one cycle after a tick, far from the next edge
    task automatic at_ph(input logic [2:0] p);
        @(posedge core_clk);
        while (ph !== p)
            @(posedge core_clk);
    endtask : at_ph
    task automatic count_ticks(input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            cnt += (int_tick === 1'b1);
        end
    endtask : count_ticks
    task automatic run_seq();
        int t;
        int f;
        int w;
        t = 0;
        f = 0;
        w = 0;
        @(posedge core_clk);
        cmp_val("vector", {4'h0, RESET_VECTOR}, {4'h0, core_ctl.pc_load});
        cmp_bit("nmi ctx", 1'b1, core_ctl.nmi_ctx_set);
        cmp_bit("stack clear", 1'b1, core_ctl.stack_clear);
        cmp_bit("io inputs", 1'b1, core_ctl.io_safe_input);
        while (core_ctl.vector_fetch !== 1'b1 && w < 30000) begin
            @(posedge core_clk);
            t += (int_tick === 1'b1 && core_ctl.vector_fetch !== 1'b1);
            w++;
        end
        while (core_ctl.vector_fetch === 1'b1 && w < 30000) begin
            @(posedge core_clk);
            f += (int_tick === 1'b1 && core_ctl.vector_fetch === 1'b1);
            w++;
        end
        cmp_val("delay ticks", 16'(RESET_DELAY_TICKS), t[15:0]);
        cmp_val("fetch ticks", 16'(VECTOR_FETCH_TICKS), f[15:0]);
        repeat (3) @(posedge core_clk);
        cmp_bit("core run", 1'b1, core_ctl.core_rst_n);
        cmp_bit("nmi ctx end", 1'b0, core_ctl.nmi_ctx_set);
    endtask : run_seq
    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // ==========================================
    // hang guard, about 51k cycles expected
    initial begin
        repeat (70000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end

    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        safeguard_option_enable = 1'b1;
        supply_monitor_option = 1'b1;
        supply_high = 1'b1;
        above_rising_threshold = 1'b1;
        above_falling_threshold = 1'b1;
        main_osc_edge = 1'b0;
        watchdog_expired = 1'b0;
        cpu_stop_mode = 1'b0;
        press = 1'b1;
        ph = 3'h0;
        bus_req = '0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        reg_rd(ADDR_ANALOG_CONVERTER_CONTROL, v);
        cmp_val("ctrl reset", {8'h00, ANALOG_CONVERTER_CONTROL_RESET}, {8'h00, v});
        at_ph(3'h0);
        press <= 1'b0;
        run_seq();
        for (i = 0; i < 5; i++) begin
            reg_wr(rows[i].addr, rows[i].wdata);
            reg_rd(rows[i].addr, v);
            cmp_val("reg readback", {8'h00, rows[i].exp}, {8'h00, v});
        end
        // both supply bands: edges every 8, kept when spaced by the band gap
        for (i = 0; i < 2; i++) begin
            supply_high <= (i == 0);
            repeat (20) @(posedge core_clk);
            count_ticks(160, n);
            cmp_val("band ticks", 16'(160 / (8 * (((i == 0 ? SG_GAP_HI_CYC : SG_GAP_LO_CYC)
                + 7) / 8))), n[15:0]);
        end
        supply_high <= 1'b1;
        reg_wr(ADDR_ANALOG_CONVERTER_CONTROL, 8'h44);
        repeat (3) @(posedge core_clk);
        cmp_bit("osc stopped", 1'b1, main_osc_stop);
        repeat (MAIN_MISS_CYC) @(posedge core_clk);
        cmp_bit("backup early", 1'b0, backup_run);
        for (i = 0; i < 60 && backup_run !== 1'b1; i++)
            @(posedge core_clk);
        cmp_bit("backup started", 1'b1, backup_run);
        count_ticks(101, n);
        cmp_val("backup ticks", 16'(100 / BACKUP_PERIOD_CYC), n[15:0]);
        reg_wr(ADDR_ANALOG_CONVERTER_CONTROL, 8'h40);
        for (i = 0; i < 40 && backup_run !== 1'b0; i++)
            @(posedge core_clk);
        cmp_bit("backup stopped", 1'b0, backup_run);
        safeguard_option_enable <= 1'b0;
        reg_wr(ADDR_ANALOG_CONVERTER_CONTROL, 8'h44);
        repeat (MAIN_MISS_CYC + BACKUP_PERIOD_CYC + 10) @(posedge core_clk);
        cmp_bit("off ignored", 1'b0, main_osc_stop);
        cmp_bit("no backup", 1'b0, backup_run);
        reg_wr(ADDR_ANALOG_CONVERTER_CONTROL, 8'h40);
        safeguard_option_enable <= 1'b1;
        // watchdog, then a short pin pulse in mid-delay restarts the count
        at_ph(3'h0);
        watchdog_expired <= 1'b1;
        @(posedge core_clk);
        watchdog_expired <= 1'b0;
        count_ticks(0, n);
        repeat (10) begin
            @(posedge core_clk);
            n += (rst_pin_oe === 1'b1);
        end
        cmp_bit("wdg pin brief", 1'b1, n > 0 && n <= 2 * WDG_PIN_CYC);
        repeat (800) @(posedge core_clk);
        cmp_bit("core held", 1'b0, core_ctl.core_rst_n);
        at_ph(3'h5);
        press <= 1'b1;
        at_ph(3'h0);
        press <= 1'b0;
        run_seq();
        above_falling_threshold <= 1'b0;
        above_rising_threshold <= 1'b0;
        repeat (10) @(posedge core_clk);
        cmp_bit("supply pin", 1'b1, rst_pin_oe);
        cmp_bit("supply core", 1'b0, core_ctl.core_rst_n);
        above_falling_threshold <= 1'b1;
        repeat (10) @(posedge core_clk);
        cmp_bit("below rising", 1'b1, rst_pin_oe);
        at_ph(3'h0);
        above_rising_threshold <= 1'b1;
        run_seq();
        above_rising_threshold <= 1'b0;
        repeat (10) @(posedge core_clk);
        cmp_bit("above falling", 1'b1, core_ctl.core_rst_n);
        // stop mode halts main; a pin reset must start it again
        cpu_stop_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        cmp_bit("stop osc", 1'b1, main_osc_stop);
        press <= 1'b1;
        repeat (8) @(posedge core_clk);
        cmp_bit("stop pin osc", 1'b0, main_osc_stop);
        cmp_bit("stop pin io", 1'b1, core_ctl.io_safe_input);
        cmp_bit("stop pin core", 1'b0, core_ctl.core_rst_n);
        end_of_test();
    end
endmodule : cs_clock_reset_bench

bind cs_clock_reset cs_clock_reset_asserts cs_clock_reset_asserts_inst (.core_clk(core_clk),
    .rstn(rstn), .safeguard_option_enable(safeguard_option_enable),
    .supply_monitor_option(supply_monitor_option), .supply_high(supply_high),
    .above_falling_threshold(above_falling_threshold), .main_osc_edge(main_osc_edge),
    .watchdog_expired(watchdog_expired), .rst_pin_in(rst_pin_in), .bus_req(bus_req),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .rdata(rdata),
    .int_tick(int_tick), .backup_run(backup_run), .core_ctl(core_ctl));
